// [common/codec_regs_pkg.sv]
// register map, field positions and reset values for the mixer and power
// control register bank; shared by the bank and its two helper modules
package codec_regs_pkg;

	// bus geometry: a register's byte address is four times its index
	localparam int ADDR_W   = 8;
	localparam int DATA_W   = 32;
	localparam int REG_W    = 16;
	localparam int NUM_REGS = 17;
	localparam int SLOT_W   = 5;
	localparam int IDX_LSB  = 2;
	localparam int IDX_W    = 6;

	// register indices as printed
	localparam logic [IDX_W-1:0] IDX_LINE_INPUT = 6'h10;
	localparam logic [IDX_W-1:0] IDX_AUX_DAC    = 6'h12;
	localparam logic [IDX_W-1:0] IDX_SIDETONE   = 6'h14;
	localparam logic [IDX_W-1:0] IDX_THIRD_OUT  = 6'h16;
	localparam logic [IDX_W-1:0] IDX_STEREO_DAC = 6'h18;
	localparam logic [IDX_W-1:0] IDX_REC_SELECT = 6'h1A;
	localparam logic [IDX_W-1:0] IDX_REC_GAIN   = 6'h1C;
	localparam logic [IDX_W-1:0] IDX_GENERAL    = 6'h20;
	localparam logic [IDX_W-1:0] IDX_WIDENING   = 6'h22;
	localparam logic [IDX_W-1:0] IDX_EXTRA_PD   = 6'h24;
	localparam logic [IDX_W-1:0] IDX_PD_STATUS  = 6'h26;
	localparam logic [IDX_W-1:0] IDX_EXT_CAPS   = 6'h28;
	localparam logic [IDX_W-1:0] IDX_EXT_STATUS = 6'h2A;
	localparam logic [IDX_W-1:0] IDX_DAC_RATE   = 6'h2C;
	localparam logic [IDX_W-1:0] IDX_AUX_RATE   = 6'h2E;
	localparam logic [IDX_W-1:0] IDX_ADC_RATE   = 6'h32;
	localparam logic [IDX_W-1:0] IDX_DIGOUT_CS  = 6'h3A;

	// storage slots, in the order of the tables below
	localparam int S_LINE = 0;
	localparam int S_AUX = 1;
	localparam int S_SIDE = 2;
	localparam int S_THIRD = 3;
	localparam int S_DAC = 4;
	localparam int S_RSEL = 5;
	localparam int S_RGAIN = 6;
	localparam int S_GP = 7;
	localparam int S_WIDEN = 8;
	localparam int S_XPD = 9;
	localparam int S_PWR = 10;
	localparam int S_CAPS = 11;
	localparam int S_EXT = 12;
	localparam int S_DRATE = 13;
	localparam int S_ARATE = 14;
	localparam int S_ADCR = 15;
	localparam int S_DIGOUT = 16;
	localparam logic [SLOT_W-1:0] SLOT_NONE = 5'h1F;

	localparam logic [IDX_W-1:0] SLOT_IDX [NUM_REGS] = '{
		IDX_LINE_INPUT, IDX_AUX_DAC, IDX_SIDETONE, IDX_THIRD_OUT,
		IDX_STEREO_DAC, IDX_REC_SELECT, IDX_REC_GAIN, IDX_GENERAL,
		IDX_WIDENING, IDX_EXTRA_PD, IDX_PD_STATUS, IDX_EXT_CAPS,
		IDX_EXT_STATUS, IDX_DAC_RATE, IDX_AUX_RATE, IDX_ADC_RATE,
		IDX_DIGOUT_CS};
	// bits that software may write
	localparam logic [REG_W-1:0] SLOT_MASK [NUM_REGS] = '{
		16'hFF1F, 16'hFFF1, 16'hFF80, 16'h87BF, 16'hFF1F, 16'h7F07,
		16'hFFFF, 16'h2080, 16'h003F, 16'hFFFF, 16'h7F00, 16'h0000,
		16'h0035, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h8FFF};
	localparam logic [REG_W-1:0] SLOT_RESET [NUM_REGS] = '{
		16'hE808, 16'hAAA0, 16'hAD00, 16'h8000, 16'hE808, 16'h3000,
		16'h8000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0010, 16'hBB80, 16'hBB80, 16'hBB80, 16'h0000};
	// read-only bits with a constant value
	localparam logic [REG_W-1:0] SLOT_FIXED [NUM_REGS] = '{
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0405,
		16'h0400, 16'h0000, 16'h0000, 16'h0000, 16'h2000};

	// field positions
	localparam int BIT_SPK_MUTE    = 14;
	localparam int BIT_PHONE_MUTE  = 13;
	localparam int GAIN_LEFT_LSB   = 8;
	localparam int GAIN_RIGHT_LSB  = 0;
	localparam int GAIN5_W         = 5;
	localparam logic [GAIN5_W-1:0] GAIN5_0DB = 5'h08;
	localparam int BIT_AUX_ENABLE  = 0;
	localparam int LEVEL_ROUTE_LSB = 10;
	localparam int R2P_ROUTE_LSB   = 12;
	localparam int THIRD_SRC_LSB   = 9;
	localparam int BIT_SPK_SRC     = 8;
	localparam int SLOT_SEL_LSB    = 4;
	localparam int BIT_DIGOUT_EN   = 2;
	localparam int BIT_VRA         = 0;
	localparam int BIT_WIDEN_EN    = 13;
	localparam int BIT_LOOPBACK    = 7;
	localparam int BIT_OSC_OFF     = 15;
	localparam int BIT_INTCLK_OFF  = 13;
	localparam int BIT_LINK_OFF    = 12;

	// standard power-down field and its ready flags
	localparam int PR_LSB = 8;
	localparam int PR_W = 7;
	localparam int PR0 = 0;
	localparam int PR1 = 1;
	localparam int PR2 = 2;
	localparam int PR3 = 3;
	localparam int RDY_REF = 3;
	localparam int RDY_ANL = 2;
	localparam int RDY_DAC = 1;
	localparam int RDY_ADC = 0;
	localparam int PD_W = 16;
	// which standard disable bit also governs each extra power-down block
	localparam logic [2:0] PD_TO_PR [PD_W] = '{
		3'h3, 3'h3, 3'h3, 3'h2, 3'h6, 3'h6, 3'h2, 3'h2,
		3'h2, 3'h2, 3'h3, 3'h0, 3'h0, 3'h1, 3'h1, 3'h5};

	localparam int ROUTE_W = 2;
	localparam logic [ROUTE_W-1:0] ROUTE_BOTH = 2'h0;
	localparam logic [ROUTE_W-1:0] ROUTE_MUTE = 2'h3;
	localparam logic [REG_W-1:0] RATE_48K = 16'hBB80;

	// index to storage slot, SLOT_NONE when unmapped
	function automatic logic [SLOT_W-1:0] slot_of(
		input logic [IDX_W-1:0] idx);
		logic [SLOT_W-1:0] s;
		s = SLOT_NONE;
		for (int i = 0; i < NUM_REGS; i++)
		begin
			if (SLOT_IDX[i] == idx)
				s = SLOT_W'(i);
		end
		return s;
	endfunction

	// 2-bit route code to {left_on, right_on}; left_code names left-only
	function automatic logic [1:0] route_decode(
		input logic [ROUTE_W-1:0] code,
		input logic [ROUTE_W-1:0] left_code);
		logic [1:0] r;
		r = 2'h0;
		if (code == ROUTE_BOTH)
			r = 2'h3;
		else if (code == left_code)
			r = 2'h2;
		else if (code != ROUTE_MUTE)
			r = 2'h1;
		return r;
	endfunction

	// 2-bit selector to one-hot
	function automatic logic [3:0] onehot4(input logic [1:0] code);
		return 4'h1 << code;
	endfunction

endpackage

// [rtl/power_combine.sv]
// effective power state of each circuit block from both power-down regs
// assumes the disable bits come from flip-flops in the same clock domain
`timescale 1ns/1ps
`default_nettype none
module power_combine
	import codec_regs_pkg::*;
(
	input  wire logic                           ref_clk_i,
	input  wire logic                           rst_b_i,
	input  wire logic [codec_regs_pkg::PD_W-1:0] extra_pd_i,
	input  wire logic [codec_regs_pkg::PR_W-1:0] std_pd_i,
	output logic      [codec_regs_pkg::PD_W-1:0] block_on_o
);
	import codec_regs_pkg::*;

	logic [PD_W-1:0] std_spread;

	// each block also looks at the standard bit that covers it
	always_comb
	begin
		for (int i = 0; i < PD_W; i++)
			std_spread[i] = std_pd_i[PD_TO_PR[i]];
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_b_i)
			block_on_o <= '0;
		else
			block_on_o <= ~(extra_pd_i | std_spread);
	end

	chk_power_both_zero:
	assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		$past(rst_b_i) |-> block_on_o ==
		~($past(extra_pd_i) | $past(std_spread)))
	else $error("block power state does not follow disable bits");

endmodule // power_combine
`default_nettype wire

// [rtl/rate_gate.sv]
// effective sample rate: the programmed rate only while variable rate is on
// assumes rate and enable come from flip-flops in the same clock domain
`timescale 1ns/1ps
`default_nettype none
module rate_gate
	import codec_regs_pkg::*;
#(
	parameter int W = 16
)
(
	input  wire logic         ref_clk_i,
	input  wire logic         rst_b_i,
	input  wire logic         vra_i,
	input  wire logic [W-1:0] rate_i,
	output logic      [W-1:0] rate_eff_o
);
	import codec_regs_pkg::*;

	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_b_i)
			rate_eff_o <= W'(RATE_48K);
		else
			rate_eff_o <= vra_i ? rate_i : W'(RATE_48K);
	end

	chk_rate_fixed_off:
	assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		$past(rst_b_i) && !$past(vra_i) |-> rate_eff_o == W'(RATE_48K))
	else $error("rate changed while variable rate disabled");

endmodule // rate_gate
`default_nettype wire

// [rtl/codec_mixer_regs.sv]
// mixer, routing, power-down and variable-rate register bank of the codec
// assumes an Avalon-MM master in the same clock domain and a strap pin
// that is stable while reset is held
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module codec_mixer_regs
	import codec_regs_pkg::*;
(
	input  wire logic                              ref_clk_i,
	input  wire logic                              rst_b_i,
	input  wire logic                              strap_power_off_i,
	input  wire logic [codec_regs_pkg::ADDR_W-1:0] avs_address_i,
	input  wire logic                              avs_read_i,
	input  wire logic                              avs_write_i,
	input  wire logic [codec_regs_pkg::DATA_W-1:0] avs_writedata_i,
	input  wire logic [3:0]                        avs_byteenable_i,
	output logic      [codec_regs_pkg::DATA_W-1:0] avs_readdata_o,
	output logic                                   avs_waitrequest_o,
	output logic      [codec_regs_pkg::REG_W-1:0]  line_input_o,
	output logic      [codec_regs_pkg::REG_W-1:0]  aux_dac_routing_o,
	output logic      [codec_regs_pkg::REG_W-1:0]  sidetone_control_o,
	output logic      [codec_regs_pkg::REG_W-1:0]  third_output_control_o,
	output logic      [codec_regs_pkg::REG_W-1:0]  stereo_dac_routing_o,
	output logic      [codec_regs_pkg::REG_W-1:0]  record_select_o,
	output logic      [codec_regs_pkg::REG_W-1:0]  record_gain_o,
	output logic      [codec_regs_pkg::REG_W-1:0]  stereo_widening_control_o,
	output logic      [codec_regs_pkg::REG_W-1:0]  extra_power_down_o,
	output logic      [codec_regs_pkg::REG_W-1:0]  power_down_status_o,
	output logic      [codec_regs_pkg::REG_W-1:0]  extended_status_control_o,
	output logic      [codec_regs_pkg::REG_W-1:0]  digital_out_channel_status_o,
	output logic      [codec_regs_pkg::REG_W-1:0]  stereo_converter_rate_o,
	output logic      [codec_regs_pkg::REG_W-1:0]  aux_converter_rate_o,
	output logic      [codec_regs_pkg::REG_W-1:0]  record_converter_rate_o,
	output logic      [codec_regs_pkg::PD_W-1:0]   block_power_on_o,
	output logic                                   oscillator_disable_o,
	output logic                                   internal_clock_disable_o,
	output logic                                   link_interface_disable_o,
	output logic                                   aux_converter_enable_o,
	output logic                                   widening_enable_o,
	output logic                                   loopback_enable_o,
	output logic                                   digital_out_enable_o,
	output logic      [1:0]                        level_ctrl_route_o,
	output logic      [1:0]                        record_to_phone_route_o,
	output logic      [3:0]                        third_output_source_o,
	output logic                                   speaker_pair_source_o,
	output logic      [3:0]                        digital_out_slot_select_o
);
	import codec_regs_pkg::*;

	logic [REG_W-1:0]  regs_reg [NUM_REGS];
	logic              wait_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [IDX_W-1:0]  idx;
	logic [SLOT_W-1:0] slot;
	logic              mapped;
	logic              req;
	logic              accept;
	logic [REG_W-1:0]  lane_mask;
	logic [REG_W-1:0]  write_mask;
	logic [REG_W-1:0]  rd_val;
	logic [PR_W-1:0]   std_pd;

	// address decode; byte offset bits are ignored, words are aligned
	assign idx = avs_address_i[IDX_LSB +: IDX_W];
	assign slot = slot_of(idx);
	assign mapped = (slot != SLOT_NONE);
	assign req = avs_read_i | avs_write_i;
	assign accept = req & ~wait_reg;
	assign std_pd = regs_reg[S_PWR][PR_LSB +: PR_W];

	// only the low two byte lanes carry register bits
	assign lane_mask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

	assign write_mask = mapped ? (SLOT_MASK[slot] & lane_mask) : '0;

	// waitrequest drops for one cycle, one cycle after a request appears;
	// a fixed one-cycle answer keeps the bank free of access queues
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_b_i)
			wait_reg <= 1'b1;
		else if (accept)
			wait_reg <= 1'b1;
		else if (req)
			wait_reg <= 1'b0;
	end

	// read value: stored writable bits plus fixed and live read-only bits
	always_comb
	begin
		rd_val = '0;
		if (mapped)
		begin
			rd_val = (regs_reg[slot] & SLOT_MASK[slot]) | SLOT_FIXED[slot];
			if (slot == SLOT_W'(S_PWR))
			begin
				rd_val[RDY_REF] = ~std_pd[PR2];
				rd_val[RDY_ANL] = ~std_pd[PR3];
				rd_val[RDY_DAC] = ~std_pd[PR1];
				rd_val[RDY_ADC] = ~std_pd[PR0];
			end
		end
	end

	// read data is captured one edge early so it stands at the accept edge;
	// unmapped reads answer zero
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_b_i)
			rdata_reg <= '0;
		else if (avs_read_i && wait_reg)
			rdata_reg <= {{(DATA_W - REG_W){1'b0}}, rd_val};
	end

	// register storage; writes take effect only on the accept edge
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_b_i)
		begin
			for (int i = 0; i < NUM_REGS; i++)
				regs_reg[i] <= SLOT_RESET[i];
			regs_reg[S_PWR] <= {1'b0, {PR_W{strap_power_off_i}},
				{PR_LSB{1'b0}}};
		end
		else if (accept && avs_write_i && mapped)
		begin
			regs_reg[slot] <= (regs_reg[slot] & ~write_mask) |
				(avs_writedata_i[REG_W-1:0] & write_mask);
		end
	end

	// decoded routing and source selects, registered so every output is a flop
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_b_i)
		begin
			level_ctrl_route_o <= 2'h0;
			record_to_phone_route_o <= 2'h0;
			third_output_source_o <= 4'h1;
			speaker_pair_source_o <= 1'b0;
			digital_out_slot_select_o <= 4'h2;
		end
		else
		begin
			level_ctrl_route_o <= route_decode(
				regs_reg[S_SIDE][LEVEL_ROUTE_LSB +: ROUTE_W], 2'h2);
			record_to_phone_route_o <= route_decode(
				regs_reg[S_RSEL][R2P_ROUTE_LSB +: ROUTE_W], 2'h1);
			third_output_source_o <= onehot4(
				regs_reg[S_THIRD][THIRD_SRC_LSB +: ROUTE_W]);
			speaker_pair_source_o <= regs_reg[S_THIRD][BIT_SPK_SRC];
			digital_out_slot_select_o <= onehot4(
				regs_reg[S_EXT][SLOT_SEL_LSB +: ROUTE_W]);
		end
	end

	// register contents straight from storage
	assign avs_readdata_o = rdata_reg;
	assign avs_waitrequest_o = wait_reg;
	assign line_input_o = regs_reg[S_LINE];
	assign aux_dac_routing_o = regs_reg[S_AUX];
	assign sidetone_control_o = regs_reg[S_SIDE];
	assign third_output_control_o = regs_reg[S_THIRD];
	assign stereo_dac_routing_o = regs_reg[S_DAC];
	assign record_select_o = regs_reg[S_RSEL];
	assign record_gain_o = regs_reg[S_RGAIN];
	assign stereo_widening_control_o = regs_reg[S_WIDEN];
	assign extra_power_down_o = regs_reg[S_XPD];
	assign power_down_status_o = regs_reg[S_PWR];
	assign extended_status_control_o = regs_reg[S_EXT];
	assign digital_out_channel_status_o = regs_reg[S_DIGOUT];
	assign aux_converter_enable_o = regs_reg[S_AUX][BIT_AUX_ENABLE];
	assign widening_enable_o = regs_reg[S_GP][BIT_WIDEN_EN];
	assign loopback_enable_o = regs_reg[S_GP][BIT_LOOPBACK];
	assign oscillator_disable_o = regs_reg[S_XPD][BIT_OSC_OFF];
	assign internal_clock_disable_o = regs_reg[S_PWR][BIT_INTCLK_OFF];
	assign link_interface_disable_o = regs_reg[S_PWR][BIT_LINK_OFF];
	assign digital_out_enable_o = regs_reg[S_EXT][BIT_DIGOUT_EN];

	// effective block power from both disable registers
	power_combine u_power_combine (
		.ref_clk_i  (ref_clk_i),
		.rst_b_i    (rst_b_i),
		.extra_pd_i (regs_reg[S_XPD]),
		.std_pd_i   (std_pd),
		.block_on_o (block_power_on_o)
	);

	// effective rates; the programmed rate only counts with variable rate
	rate_gate #(.W(REG_W)) u_rate_dac (
		.ref_clk_i  (ref_clk_i),
		.rst_b_i    (rst_b_i),
		.vra_i      (regs_reg[S_EXT][BIT_VRA]),
		.rate_i     (regs_reg[S_DRATE]),
		.rate_eff_o (stereo_converter_rate_o)
	);

	rate_gate #(.W(REG_W)) u_rate_aux (
		.ref_clk_i  (ref_clk_i),
		.rst_b_i    (rst_b_i),
		.vra_i      (regs_reg[S_EXT][BIT_VRA]),
		.rate_i     (regs_reg[S_ARATE]),
		.rate_eff_o (aux_converter_rate_o)
	);

	rate_gate #(.W(REG_W)) u_rate_adc (
		.ref_clk_i  (ref_clk_i),
		.rst_b_i    (rst_b_i),
		.vra_i      (regs_reg[S_EXT][BIT_VRA]),
		.rate_i     (regs_reg[S_ADCR]),
		.rate_eff_o (record_converter_rate_o)
	);

	chk_line_mutes_reset:
	assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		$rose(rst_b_i) |-> line_input_o[BIT_SPK_MUTE] &&
		line_input_o[BIT_PHONE_MUTE])
	else $error("line mutes not set after reset");

	chk_line_gain_reset:
	assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		$rose(rst_b_i) |->
		line_input_o[GAIN_LEFT_LSB +: GAIN5_W] == GAIN5_0DB &&
		line_input_o[GAIN_RIGHT_LSB +: GAIN5_W] == GAIN5_0DB)
	else $error("line gains not 0 dB after reset");

	chk_aux_routing_reset:
	assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		$rose(rst_b_i) |-> aux_dac_routing_o == SLOT_RESET[S_AUX])
	else $error("aux routing wrong after reset");

	chk_strap_power_reset:
	assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		$rose(rst_b_i) |-> power_down_status_o[PR_LSB +: PR_W] ==
		{PR_W{$past(strap_power_off_i)}})
	else $error("standard disables do not follow strap");

	chk_ready_flags_read:
	assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		accept && avs_read_i && idx == IDX_PD_STATUS |->
		avs_readdata_o[RDY_ADC] == ~std_pd[PR0] &&
		avs_readdata_o[RDY_DAC] == ~std_pd[PR1] &&
		avs_readdata_o[RDY_ANL] == ~std_pd[PR3] &&
		avs_readdata_o[RDY_REF] == ~std_pd[PR2])
	else $error("ready flags not inverse of disables");

	chk_caps_read_value:
	assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		accept && avs_read_i && idx == IDX_EXT_CAPS |->
		avs_readdata_o == {16'h0000, SLOT_FIXED[S_CAPS]})
	else $error("capability register reads wrong value");

	chk_digout_fixed_bits:
	assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		accept && avs_read_i && idx == IDX_DIGOUT_CS |->
		(avs_readdata_o[REG_W-1:0] & ~SLOT_MASK[S_DIGOUT]) ==
		SLOT_FIXED[S_DIGOUT])
	else $error("channel status fixed bits wrong");

	chk_general_two_bits:
	assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		accept && avs_write_i && idx == IDX_GENERAL |=>
		(regs_reg[S_GP] & ~SLOT_MASK[S_GP]) == '0 ##1
		avs_waitrequest_o)
	else $error("general register holds unimplemented bits");

	chk_slot_select_reset:
	assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		$rose(rst_b_i) ##1 1'b1 |-> digital_out_slot_select_o == 4'h2)
	else $error("digital out slot select not 6/9 after reset");

	chk_wait_one_cycle:
	assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		$rose(req) && wait_reg |=> !avs_waitrequest_o ##1
		avs_waitrequest_o)
	else $error("waitrequest low not exactly one cycle");

	chk_readdata_upper_zero:
	assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		accept && avs_read_i |-> avs_readdata_o[DATA_W-1:REG_W] == '0)
	else $error("read data upper half not zero");

endmodule // codec_mixer_regs
`default_nettype wire

// [verification/avs_host_model.sv]
// host-side master model for the register bus of the mixer bank
// assumes the bank answers with waitrequest in the same clock domain
`timescale 1ns/1ps
`default_nettype none
module avs_host_model
(
	input  wire logic        ref_clk_i,
	input  wire logic        waitrequest_i,
	input  wire logic [31:0] readdata_i,
	output logic      [7:0]  address_o,
	output logic             read_o,
	output logic             write_o,
	output logic      [31:0] writedata_o,
	output logic      [3:0]  byteenable_o
);
	// bus idle from time zero
	initial
	begin
		address_o = 8'h00;
		read_o = 1'b0;
		write_o = 1'b0;
		writedata_o = 32'h00000000;
		byteenable_o = 4'h0;
	end

	// one access, held until waitrequest is sampled low at a rising edge
	task automatic access(input logic we, input logic [7:0] a,
		input logic [15:0] d, output logic [15:0] q, output logic ok);
		int n;
		n = 0;
		address_o <= a;
		read_o <= ~we;
		write_o <= we;
		writedata_o <= {16'h0000, d};
		byteenable_o <= 4'h3;
		do
		begin
			@(posedge ref_clk_i);
			n++;
		end
		while (waitrequest_i !== 1'b0 && n < 64);
		q = readdata_i[15:0];
		ok = (waitrequest_i === 1'b0);
		read_o <= 1'b0;
		write_o <= 1'b0;
		// stale lines scrambled so nothing leans on old values
		address_o <= ~a;
		writedata_o <= ~writedata_o;
		@(posedge ref_clk_i);
	endtask
endmodule // avs_host_model
`default_nettype wire

// [verification/test_codec_mixer_regs.sv]
// self-checking bench for the mixer and power register bank
// assumes the host model is the only master on the register bus
`timescale 1ns/1ps
`default_nettype none
module test_codec_mixer_regs;
	import codec_regs_pkg::*;
	localparam logic [5:0] IX [17] = '{6'h10, 6'h12, 6'h14, 6'h16, 6'h18,
		6'h1A, 6'h1C, 6'h20, 6'h22, 6'h24, 6'h26, 6'h28, 6'h2A, 6'h2C,
		6'h2E, 6'h32, 6'h3A};
	localparam logic [15:0] RS [17] = '{16'hE808, 16'hAAA0, 16'hAD00,
		16'h8000, 16'hE808, 16'h3000, 16'h8000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0010, 16'hBB80, 16'hBB80,
		16'hBB80, 16'h0000};
	localparam logic [15:0] WM [17] = '{16'hFF1F, 16'hFFF1, 16'hFF80,
		16'h87BF, 16'hFF1F, 16'h7F07, 16'hFFFF, 16'h2080, 16'h003F,
		16'hFFFF, 16'h7F00, 16'h0000, 16'h0035, 16'hFFFF, 16'hFFFF,
		16'hFFFF, 16'h8FFF};
	logic        ref_clk_i = 1'b0;
	logic        rst_b_i = 1'b0;
	logic        strap = 1'b0;
	logic [7:0]  adr;
	logic        rd;
	logic        wr;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic [3:0]  be;
	logic        wreq;
	logic [15:0] rate_dac;
	logic [15:0] rate_aux;
	logic [15:0] rate_adc;
	// stored register outputs, indexed like the slot tables above
	logic [16:0][15:0] st;
	logic        wid, lpb, aux_en, dig_en, clk_off;
	logic [15:0] pwr_on;
	logic        osc_off;
	logic        link_off;
	logic [1:0]  lvl;
	logic [1:0]  r2p;
	logic [3:0]  third;
	logic        spk;
	logic [3:0]  slot;
	logic [15:0] q;
	logic [15:0] d;
	logic [1:0]  cc;
	logic [15:0] sh [17];
	int          n_mismatch = 0;
	int          n_compared = 0;
	int          seed;

	always #2 ref_clk_i = ~ref_clk_i;

	codec_mixer_regs i_codec_mixer_regs (
		.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .strap_power_off_i(strap),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wdat), .avs_byteenable_i(be),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
		.line_input_o(st[0]), .aux_dac_routing_o(st[1]),
		.sidetone_control_o(st[2]), .third_output_control_o(st[3]),
		.stereo_dac_routing_o(st[4]), .record_select_o(st[5]),
		.record_gain_o(st[6]), .stereo_widening_control_o(st[8]),
		.extra_power_down_o(st[9]), .power_down_status_o(st[10]),
		.extended_status_control_o(st[12]),
		.digital_out_channel_status_o(st[16]),
		.stereo_converter_rate_o(rate_dac), .aux_converter_rate_o(rate_aux),
		.record_converter_rate_o(rate_adc), .block_power_on_o(pwr_on),
		.oscillator_disable_o(osc_off), .internal_clock_disable_o(clk_off),
		.link_interface_disable_o(link_off), .aux_converter_enable_o(aux_en),
		.widening_enable_o(wid), .loopback_enable_o(lpb),
		.digital_out_enable_o(dig_en),
		.level_ctrl_route_o(lvl), .record_to_phone_route_o(r2p),
		.third_output_source_o(third), .speaker_pair_source_o(spk),
		.digital_out_slot_select_o(slot));

	avs_host_model i_avs_host_model (.ref_clk_i(ref_clk_i),
		.waitrequest_i(wreq), .readdata_i(rdat), .address_o(adr),
		.read_o(rd), .write_o(wr), .writedata_o(wdat), .byteenable_o(be));

	task automatic results();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	// a hung access counts as a mismatch and ends the run
	task automatic rw(input logic we, input logic [7:0] a,
		input logic [15:0] v);
		logic ok;
		i_avs_host_model.access(we, a, v, q, ok);
		if (!ok)
		begin
			n_mismatch++;
			results();
		end
	endtask

	// readback: stored bits, fixed ones, ready flags as inverted disables
	function automatic logic [15:0] exp_rd(input int i, input logic [15:0] s);
		logic [15:0] v;
		v = s & WM[i];
		if (i == 11)
			v = v | 16'h0405;
		if (i == 12)
			v = v | 16'h0400;
		if (i == 16)
			v = v | 16'h2000;
		if (i == 10)
			v = v | {12'h000, ~s[10], ~s[11], ~s[9], ~s[8]};
		return v;
	endfunction

	task automatic do_reset(input logic s);
		rst_b_i <= 1'b0;
		strap <= s;
		repeat (5) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		@(posedge ref_clk_i);
		sh = RS;
		sh[10] = s ? 16'h7F00 : 16'h0000;
	endtask

	// bus readback plus the stored-register and enable outputs
	task automatic read_all();
		logic [4:0] e;
		for (int i = 0; i < 17; i++)
		begin
			rw(1'b0, {IX[i], 2'h0}, 16'h0000);
			check(q, exp_rd(i, sh[i]));
			if (i != 7 && i != 11 && i < 13 || i == 16)
				check(st[i], sh[i] & WM[i]);
		end
		e = {sh[7][13], sh[7][7], sh[1][0], sh[12][2], sh[10][13]};
		check({wid, lpb, aux_en, dig_en, clk_off}, e);
	endtask

	task automatic settle();
		repeat (3) @(posedge ref_clk_i);
	endtask

	initial
	begin
		seed = $urandom(32'h7957278C);
		do_reset(1'b1);
		read_all();
		do_reset(1'b0);
		read_all();
		// random contents through every register, read-only ones included
		repeat (3)
		begin
			for (int i = 0; i < 17; i++)
			begin
				d = 16'($urandom);
				rw(1'b1, {IX[i], 2'h0}, d);
				sh[i] = d & WM[i];
			end
			read_all();
		end
		rw(1'b1, 8'hC0, 16'hFFFF);
		rw(1'b0, 8'hC0, 16'h0000);
		check(q, 16'h0000);
		// a new rate is only honoured once variable rate is on
		rw(1'b1, 8'hA8, 16'h0000);
		rw(1'b1, 8'hB0, 16'h1F40);
		settle();
		check(rate_dac, 16'hBB80);
		check(rate_aux, 16'hBB80);
		check(rate_adc, 16'hBB80);
		rw(1'b1, 8'hA8, 16'h0001);
		settle();
		check(rate_dac, 16'h1F40);
		check(rate_aux, sh[14]);
		check(rate_adc, sh[15]);
		// every code of the route and source selectors
		for (int c = 0; c < 4; c++)
		begin
			cc = 2'(c);
			rw(1'b1, 8'h50, {4'h0, cc, 10'h000});
			rw(1'b1, 8'h68, {2'h0, cc, 12'h000});
			rw(1'b1, 8'h58, {5'h00, cc, cc[0], 8'h00});
			rw(1'b1, 8'hA8, {10'h000, cc, 4'h0});
			settle();
			check(lvl, {~cc[0], ~cc[1]});
			check(r2p, {~cc[1], ~cc[0]});
			check(third, 4'h1 << cc);
			check(spk, cc[0]);
			check(slot, 4'h1 << cc);
		end
		rw(1'b1, 8'h98, 16'h0000);
		rw(1'b1, 8'h90, 16'h8000);
		settle();
		check(pwr_on, 16'h7FFF);
		check(osc_off, 1'b1);
		rw(1'b1, 8'h90, 16'h0000);
		rw(1'b1, 8'h98, 16'h7F00);
		settle();
		check(pwr_on, 16'h0000);
		check(link_off, 1'b1);
		results();
	end
endmodule // test_codec_mixer_regs
`default_nettype wire
